// ---- inc/kwi_pkg.sv ----
/*
  Package for the keypad wakeup interrupt block: register offsets, field
  positions, reset values and the address decode shared by the design.
  Assumes a 32-bit APB slave with each register in one aligned word.
*/
package kwi_pkg;

  // Number of keypad pins.
  localparam int KWI_PINS = 8;

  // Register byte offsets on the APB.
  localparam logic [7:0] KWI_OFS_SCR = 8'h00;
  localparam logic [7:0] KWI_OFS_ENA = 8'h04;
  localparam logic [7:0] KWI_OFS_POL = 8'h08;
  localparam logic [7:0] KWI_OFS_DIR = 8'h0C;
  localparam logic [7:0] KWI_OFS_DAT = 8'h10;
  localparam logic [7:0] KWI_OFS_BRK = 8'h14;

  // One-hot register select codes.
  localparam logic [5:0] KWI_SEL_NONE = 6'h00;
  localparam logic [5:0] KWI_SEL_SCR = 6'h01;
  localparam logic [5:0] KWI_SEL_ENA = 6'h02;
  localparam logic [5:0] KWI_SEL_POL = 6'h04;
  localparam logic [5:0] KWI_SEL_DIR = 6'h08;
  localparam logic [5:0] KWI_SEL_DAT = 6'h10;
  localparam logic [5:0] KWI_SEL_BRK = 6'h20;

  // Field positions in the status and control register.
  localparam int KWI_SCR_MODE = 0;
  localparam int KWI_SCR_MASK = 1;
  localparam int KWI_SCR_ACK = 2;
  localparam int KWI_SCR_FLAG = 3;
  // Field position of the break clear enable.
  localparam int KWI_BRK_BCE = 0;

  // Reset values of the byte-wide registers.
  localparam logic [7:0] KWI_BYTE_RST = 8'h00;
  localparam logic [31:0] KWI_WORD_ZERO = 32'h0000_0000;

  // Status and control register as read back.
  typedef struct packed {
    logic [3:0] zero;  // Unused upper bits.
    logic flag;        // Pending flag.
    logic ack;         // Acknowledge, always reads 0.
    logic mask;        // Pending mask.
    logic mode;        // Trigger sensitivity.
  } kwi_scr_t;

  // Pin-side signal group driven by the block.
  typedef struct packed {
    logic [7:0] pin_out;   // Port output data.
    logic [7:0] pin_oe_n;  // Output enable, low while driving.
    logic [7:0] pull_up;   // Pullup enables.
    logic [7:0] pull_dn;   // Pulldown enables.
  } kwi_pins_t;

  // Decodes an APB byte address into a one-hot register select.
  function automatic logic [5:0] kwi_decode(input logic [7:0] addr);
    case (addr)
      KWI_OFS_SCR: kwi_decode = KWI_SEL_SCR;
      KWI_OFS_ENA: kwi_decode = KWI_SEL_ENA;
      KWI_OFS_POL: kwi_decode = KWI_SEL_POL;
      KWI_OFS_DIR: kwi_decode = KWI_SEL_DIR;
      KWI_OFS_DAT: kwi_decode = KWI_SEL_DAT;
      KWI_OFS_BRK: kwi_decode = KWI_SEL_BRK;
      default: kwi_decode = KWI_SEL_NONE;
    endcase
  endfunction : kwi_decode

endpackage : kwi_pkg

// ---- rtl/kwi_sync.sv ----
/*
  Two-stage synchroniser for the eight keypad pins.
  Assumes the pins are asynchronous to pclk.
*/
module kwi_sync
  import kwi_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Raw and synchronised pins.
  input wire logic [KWI_PINS-1:0] raw_in,
  output logic [KWI_PINS-1:0] sync_out
);

  // First stage, read only by the second stage.
  logic [KWI_PINS-1:0] meta_q;

  // One two-flop chain per pin.
  genvar g;
  generate
    for (g = 0; g < KWI_PINS; g++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[g] <= 1'b0;
          sync_out[g] <= 1'b0;
        end else begin
          meta_q[g] <= raw_in[g];
          sync_out[g] <= meta_q[g];
        end
      end
    end
  endgenerate

endmodule : kwi_sync

// ---- rtl/kwi_top.sv ----
/*
  Keypad wakeup interrupt block: eight port pins with per-pin enable and
  polarity, edge-only or edge-and-level detection, one pending latch with
  mask, acknowledge and flag, one interrupt request, and an APB slave.
  Assumes a single pclk domain, an APB master keeping the usual protocol,
  and a CPU that pulses vector_ack for one cycle on the vector fetch.
*/
module kwi_top
  import kwi_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Port pins, each as input, output and active-low output enable.
  input wire logic [KWI_PINS-1:0] pin_in,
  output logic [KWI_PINS-1:0] pin_out,
  output logic [KWI_PINS-1:0] pin_oe_n,
  // Pull device enables.
  output logic [KWI_PINS-1:0] pull_up_en,
  output logic [KWI_PINS-1:0] pull_down_en,
  // CPU and system side.
  input wire logic vector_ack,
  input wire logic break_active,
  output logic irq_req,
  output logic wake_req
);

  // Configuration registers.
  logic [7:0] ena_q;   // Pin enable bits.
  logic [7:0] pol_q;   // Polarity select bits.
  logic [7:0] dir_q;   // Port direction, 1 drives the pin unless its enable bit is set.
  logic [7:0] dat_q;   // Port output data latch.
  logic mode_q;        // Trigger sensitivity.
  logic mask_q;        // Pending mask.
  logic bce_q;         // Break clear enable.

  // Interrupt state.
  logic pend_q;        // Pending request latch.
  logic pend_d;        // Next value of the latch.
  logic ackseen_q;     // Acknowledge held until pins release.
  logic ackseen_d;     // Next value of the held acknowledge.

  // Pin samples.
  logic [7:0] pin_s;   // Synchronised pin levels.
  logic [7:0] prev_q;  // Levels one pclk cycle earlier.

  // Detection terms.
  logic [7:0] level_v; // Enabled pins at their asserted level.
  logic [7:0] edge_v;  // Enabled pins with an active edge now.
  logic any_level;     // Some enabled pin is asserted.
  logic other_busy;    // An asserted pin that is not edging now.
  logic set_req;       // Request to set the latch.
  logic clr_req;       // Request to clear the latch.
  logic sw_ack;        // Effective software acknowledge.

  // Bus decode terms.
  logic [5:0] sel;     // One-hot register select.
  logic wr_en;         // Write taken this cycle.
  logic rd_setup;      // Read setup phase.
  logic [7:0] wbyte;   // Low byte of write data.
  kwi_scr_t scr_rd;    // Status register read view.
  kwi_pins_t pins;     // Pin-side outputs.
  logic [31:0] rd_mux; // Read data before registering.
  logic [31:0] rdata_q;// Registered read data.

  // Pin synchroniser.
  kwi_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in(pin_in),
    .sync_out(pin_s)
  );

  // Address decode and transfer qualifiers.
  assign sel = kwi_decode(paddr);
  assign wr_en = psel & penable & pwrite & pready & pstrb[0];
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wbyte = pwdata[7:0];

  // The slave never inserts wait states.
  assign pready = 1'b1;
  // Unmapped addresses answer with an error in the access phase.
  assign pslverr = psel & penable & (sel == KWI_SEL_NONE);

  // Pin enable bits, cleared by reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ena_q <= KWI_BYTE_RST;
    end else if (wr_en && sel == KWI_SEL_ENA) begin
      ena_q <= wbyte;
    end
  end

  // Polarity select bits, cleared by reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_q <= KWI_BYTE_RST;
    end else if (wr_en && sel == KWI_SEL_POL) begin
      pol_q <= wbyte;
    end
  end

  // Port direction and data latch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= KWI_BYTE_RST;
      dat_q <= KWI_BYTE_RST;
    end else begin
      if (wr_en && sel == KWI_SEL_DIR) begin
        dir_q <= wbyte;
      end
      if (wr_en && sel == KWI_SEL_DAT) begin
        dat_q <= wbyte;
      end
    end
  end

  // Mode and mask bits of the status register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'b0;
      mask_q <= 1'b0;
    end else if (wr_en && sel == KWI_SEL_SCR) begin
      mode_q <= wbyte[KWI_SCR_MODE];
      mask_q <= wbyte[KWI_SCR_MASK];
    end
  end

  // Break clear enable, keeping software acknowledges off the latch during break by default.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bce_q <= 1'b0;
    end else if (wr_en && sel == KWI_SEL_BRK) begin
      bce_q <= wbyte[KWI_BRK_BCE];
    end
  end

  // Previous-cycle sample of each synchronised pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= KWI_BYTE_RST;
    end else begin
      prev_q <= pin_s;
    end
  end

  // Level and edge detection per pin.
  genvar g;
  generate
    for (g = 0; g < KWI_PINS; g++) begin : g_det
      // A pin is asserted when its level equals its polarity bit.
      assign level_v[g] = ena_q[g] & (pin_s[g] == pol_q[g]);
      // An edge is the inactive level then the active level.
      assign edge_v[g] = level_v[g] & (prev_q[g] != pol_q[g]);
    end
  endgenerate

  // Summary terms across the pins.
  assign any_level = |level_v;
  // Pins already asserted before this cycle block edge-only requests.
  assign other_busy = |(level_v & ~edge_v);

  // A software acknowledge is void in break unless clearing is enabled.
  assign sw_ack = wr_en & (sel == KWI_SEL_SCR) & wbyte[KWI_SCR_ACK]
                  & (~break_active | bce_q);

  // Set and clear conditions of the pending latch.
  always_comb begin
    if (mode_q) begin
      // Any asserted pin keeps the request present.
      set_req = any_level;
      // Clearing needs an acknowledge and all pins released.
      clr_req = (vector_ack | sw_ack | ackseen_q) & ~any_level;
    end else begin
      // An edge latches only if no other pin is still asserted.
      set_req = (|edge_v) & ~other_busy;
      // Either acknowledge clears at once.
      clr_req = vector_ack | sw_ack;
    end
  end

  // Next state of the latch and the held acknowledge; a set wins.
  always_comb begin
    pend_d = pend_q;
    ackseen_d = ackseen_q;
    if (set_req) begin
      pend_d = 1'b1;
    end else if (clr_req) begin
      pend_d = 1'b0;
    end
    if (!mode_q || !pend_d) begin
      // The held acknowledge only matters in edge-and-level mode.
      ackseen_d = 1'b0;
    end else if (vector_ack || sw_ack) begin
      ackseen_d = 1'b1;
    end
  end

  // Pending latch, cleared by reset whatever the pins show.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      ackseen_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      ackseen_q <= ackseen_d;
    end
  end

  // Request to the CPU; the same level wakes the part from wait or stop.
  assign irq_req = pend_q & ~mask_q;
  assign wake_req = irq_req;

  // Pin drive: an enabled pin is always an input.
  always_comb begin
    pins.pin_out = dat_q;
    pins.pin_oe_n = ~(dir_q & ~ena_q);
    pins.pull_up = ena_q & ~pol_q;
    pins.pull_dn = ena_q & pol_q;
  end
  assign pin_out = pins.pin_out;
  assign pin_oe_n = pins.pin_oe_n;
  assign pull_up_en = pins.pull_up;
  assign pull_down_en = pins.pull_dn;

  // Status register view; the flag ignores the mask.
  always_comb begin
    scr_rd.zero = 4'h0;
    scr_rd.flag = pend_q;
    scr_rd.ack = 1'b0;
    scr_rd.mask = mask_q;
    scr_rd.mode = mode_q;
  end

  // Read multiplexer; the data register shows the pin only where its direction bit is clear.
  always_comb begin
    rd_mux = KWI_WORD_ZERO;
    case (sel)
      KWI_SEL_SCR: rd_mux[7:0] = scr_rd;
      KWI_SEL_ENA: rd_mux[7:0] = ena_q;
      KWI_SEL_POL: rd_mux[7:0] = pol_q;
      KWI_SEL_DIR: rd_mux[7:0] = dir_q;
      KWI_SEL_DAT: rd_mux[7:0] = (pin_s & ~dir_q) | (dat_q & dir_q);
      KWI_SEL_BRK: rd_mux[KWI_BRK_BCE] = bce_q;
      default: rd_mux = KWI_WORD_ZERO;
    endcase
  end

  // Read data is registered at the setup edge for the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= KWI_WORD_ZERO;
    end else if (rd_setup) begin
      rdata_q <= rd_mux;
    end
  end
  assign prdata = rdata_q;

endmodule : kwi_top

// ---- test/kwi_keypad.sv ----
/* Keypad model for the kwi_top pins: keys, pulls and the block's drivers.
   Assumes the bench presses keys through key_on and key_lvl. */
module kwi_keypad (
  // Clock.
  input wire logic pclk,
  // Keys from the bench.
  input wire logic [7:0] key_on,
  input wire logic [7:0] key_lvl,
  // Pin drivers of the block.
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pull_up_en,
  input wire logic [7:0] pull_down_en,
  // Resolved pin levels.
  output logic [7:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_q = 8'h5A;  // Undriven pins wander every cycle.
  always_ff @(posedge pclk) begin
    float_q <= ~float_q;
  end
  // The block's driver wins, then a pressed key, then a pull device.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
      else if (key_on[i]) pin_level[i] = key_lvl[i];
      else if (pull_up_en[i]) pin_level[i] = 1'b1;
      else if (pull_down_en[i]) pin_level[i] = 1'b0;
      else pin_level[i] = float_q[i];
    end
  end
endmodule : kwi_keypad

// ---- test/kwi_top_assertions.sv ----
/* Port checker for kwi_top, with shadows of the mode, mask, enable and polarity bits.
   Assumes the register map of kwi_pkg; bound to every kwi_top. */
module kwi_chk
  import kwi_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // Pins and system side.
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pull_up_en,
  input wire logic [7:0] pull_down_en,
  input wire logic vector_ack,
  input wire logic break_active,
  input wire logic irq_req,
  input wire logic wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mode_q;  // Shadow trigger sensitivity.
  logic mask_q;  // Shadow pending mask.
  logic [7:0] ena_q;  // Shadow pin enables.
  logic [7:0] pol_q;  // Shadow polarity selects.
  logic [7:0] prev_q;  // Asserted pins one cycle ago.
  logic [7:0] calm_q;  // Cycles without writes, fetches or pin changes.
  logic wr;
  logic [7:0] asrt;
  assign wr = psel && penable && pwrite && pstrb[0];
  assign asrt = ena_q & ~(pin_in ^ pol_q);
  // Shadows follow the writes at the same edge as the block.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'b0;
      mask_q <= 1'b0;
      ena_q <= 8'h00;
      pol_q <= 8'h00;
    end else if (wr) begin
      if (paddr == KWI_OFS_SCR) mode_q <= pwdata[KWI_SCR_MODE];
      if (paddr == KWI_OFS_SCR) mask_q <= pwdata[KWI_SCR_MASK];
      if (paddr == KWI_OFS_ENA) ena_q <= pwdata[7:0];
      if (paddr == KWI_OFS_POL) pol_q <= pwdata[7:0];
    end
  end
  // Quiet-time counter, saturating, so checks wait out synchroniser lag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 8'h00;
      calm_q <= 8'h00;
    end else begin
      prev_q <= asrt;
      if (wr || vector_ack || asrt != prev_q) calm_q <= 8'h00;
      else if (calm_q != 8'hFF) calm_q <= calm_q + 8'h01;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pull_select: assert property (pull_up_en == (ena_q & ~pol_q)
    && pull_down_en == (ena_q & pol_q)) else $error("pull enables wrong");
  a_enabled_input: assert property ((ena_q & ~pin_oe_n) == 8'h00)
    else $error("enabled pin driven");
  a_mask_blocks: assert property (mask_q && $past(mask_q) |-> !irq_req)
    else $error("masked request seen");
  a_wake_follows: assert property (wake_req == irq_req)
    else $error("wake differs from request");
  a_scr_zeros: assert property (psel && penable && !pwrite && paddr == KWI_OFS_SCR
    |-> prdata[7:4] == 4'h0 && !prdata[KWI_SCR_ACK]) else $error("status zeros wrong");
  a_bad_addr: assert property (psel && penable && paddr > KWI_OFS_BRK |-> pslverr)
    else $error("no error on unmapped address");
  a_vec_clears: assert property (vector_ack && !mode_q && calm_q >= 8'h04
    |=> !irq_req) else $error("fetch did not clear");
  a_edge_sets: assert property (!mode_q && !mask_q && calm_q >= 8'h04 && prev_q == 8'h00
    && asrt != 8'h00 |-> ##[1:5] irq_req) else $error("edge not latched");
  a_level_holds: assert property (mode_q && !mask_q && asrt != 8'h00
    && calm_q >= 8'h04 |-> irq_req) else $error("level request lost");
endmodule : kwi_chk

bind kwi_top kwi_chk i_kwi_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
  .pull_down_en(pull_down_en), .vector_ack(vector_ack), .break_active(break_active),
  .irq_req(irq_req), .wake_req(wake_req));

// ---- test/testbench.sv ----
/* Self-checking bench for kwi_top: APB tasks, keypad model, scenarios.
   Assumes the register map of kwi_pkg and a zero-wait-state slave. */
module testbench
  import kwi_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic vector_ack = 1'b0;
  logic break_active = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] key_on = 8'h00;
  logic [7:0] key_lvl = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic err;  // Error response taken with the read data.
  logic pready, pslverr, irq_req, wake_req;
  logic [31:0] prdata;
  logic [7:0] pin_in, pin_out, pin_oe_n, pull_up_en, pull_down_en;
  logic [7:0] ofs [4] = '{KWI_OFS_SCR, KWI_OFS_ENA, KWI_OFS_POL, 8'h18};
  int fail_count = 0;
  int compares = 0;
  initial begin
    forever #25 pclk = ~pclk;
  end
  kwi_top i_kwi_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .vector_ack(vector_ack), .break_active(break_active), .irq_req(irq_req),
    .wake_req(wake_req));
  kwi_keypad i_kwi_keypad (.pclk(pclk), .key_on(key_on), .key_lvl(key_lvl),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .pin_level(pin_in));
  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // One APB transfer; read data lands in rd.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      wrap_up();
    end
  endtask : apb
  // Lets n edges pass, then a little settling time.
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle
  // Sets the keypad keys at a clock edge.
  task automatic keys(input logic [7:0] on, input logic [7:0] lvl);
    @(posedge pclk);
    key_on <= on;
    key_lvl <= lvl;
  endtask : keys
  // Waits a bounded time for the request to reach a level.
  task automatic wait_irq(input logic exp);
    int n;
    for (n = 0; n < 20; n++) begin
      #1;
      if (irq_req === exp) break;
      @(posedge pclk);
    end
    if (n == 20) begin
      fail_count++;
      wrap_up();
    end
  endtask : wait_irq
  // Main sequence of scenarios.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      check(rd, 32'h0);
      check(err, ofs[i] == 8'h18);
    end
    apb(1'b1, KWI_OFS_SCR, 32'h2);
    apb(1'b1, KWI_OFS_ENA, 32'hFF);
    apb(1'b1, KWI_OFS_POL, 32'h0F);
    settle(1);
    check({pull_up_en, pull_down_en}, 16'hF00F);
    apb(1'b1, KWI_OFS_SCR, 32'h6);
    apb(1'b1, KWI_OFS_SCR, 32'h0);
    keys(8'h10, 8'h00);
    wait_irq(1'b1);
    check(irq_req, 1'b1);
    apb(1'b0, KWI_OFS_SCR, 32'h0);
    check(rd, 32'h8);
    apb(1'b1, KWI_OFS_SCR, 32'h4);
    settle(1);
    check(irq_req, 1'b0);
    keys(8'h00, 8'h00);
    settle(4);
    keys(8'h01, 8'h01);
    wait_irq(1'b1);
    check(irq_req, 1'b1);
    settle(4);
    @(posedge pclk);
    vector_ack <= 1'b1;
    @(posedge pclk);
    vector_ack <= 1'b0;
    settle(1);
    check(irq_req, 1'b0);
    keys(8'h21, 8'h01);
    settle(8);
    check(irq_req, 1'b0);
    keys(8'h00, 8'h00);
    settle(4);
    apb(1'b1, KWI_OFS_SCR, 32'h4);
    keys(8'h20, 8'h00);
    wait_irq(1'b1);
    check(irq_req, 1'b1);
    apb(1'b1, KWI_OFS_SCR, 32'h2);
    settle(1);
    check({wake_req, irq_req}, 2'h0);
    apb(1'b0, KWI_OFS_SCR, 32'h0);
    check(rd, 32'hA);
    apb(1'b1, KWI_OFS_SCR, 32'h0);
    settle(1);
    check(wake_req, 1'b1);
    @(posedge pclk);
    break_active <= 1'b1;
    apb(1'b1, KWI_OFS_SCR, 32'h4);
    settle(1);
    check(irq_req, 1'b1);
    apb(1'b1, KWI_OFS_BRK, 32'h1);
    apb(1'b1, KWI_OFS_SCR, 32'h4);
    @(posedge pclk);
    break_active <= 1'b0;
    settle(2);
    check(irq_req, 1'b0);
    keys(8'h00, 8'h00);
    apb(1'b1, KWI_OFS_SCR, 32'h1);
    keys(8'h40, 8'h00);
    wait_irq(1'b1);
    check(irq_req, 1'b1);
    settle(4);
    apb(1'b1, KWI_OFS_SCR, 32'h5);
    settle(2);
    check(irq_req, 1'b1);
    keys(8'h00, 8'h00);
    wait_irq(1'b0);
    check(irq_req, 1'b0);
    keys(8'h40, 8'h00);
    wait_irq(1'b1);
    keys(8'h00, 8'h00);
    settle(6);
    check(irq_req, 1'b1);
    apb(1'b1, KWI_OFS_SCR, 32'h5);
    settle(1);
    check(irq_req, 1'b0);
    keys(8'h40, 8'h00);
    wait_irq(1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    settle(1);
    check(irq_req, 1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, KWI_OFS_SCR, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, KWI_OFS_DIR, 32'h0F);
    apb(1'b1, KWI_OFS_DAT, 32'h05);
    apb(1'b1, KWI_OFS_ENA, 32'h01);
    settle(1);
    check({pin_oe_n, pin_out[3:1]}, 11'h78A);
    wrap_up();
  end
endmodule : testbench
